/* File: design/pcrc_pkg.sv */
// Shared constants and types for the programmable CRC block
`default_nettype none
package pcrc_pkg;
  localparam int          PCRC_W          = 16;
  localparam int          PCRC_BYTE_W     = 8;
  localparam int          PCRC_FIFO_DEPTH = 32;
  localparam logic [15:0] PCRC_SEED_ONES  = 16'hffff;
  localparam logic [15:0] PCRC_SEED_ZERO  = 16'h0000;
  localparam logic [15:0] PCRC_POLY_RST   = 16'h0000;
  localparam logic [15:0] PCRC_RES_RST    = 16'h0000;
  localparam logic [7:0]  PCRC_PAGE       = 8'h02;
  localparam logic [3:0]  PCRC_DMA_SRC    = 4'h2;
  localparam int          PCRC_CFG_REQ_LSB = 0;
  localparam int          PCRC_CFG_IRQ_EN  = 7;

  typedef enum logic {
    PCRC_IDLE = 1'b0,
    PCRC_DMA  = 1'b1
  } pcrc_mode_t;

  // One processor write cycle toward the block
  typedef struct packed {
    logic       clr;
    logic       seed;
    logic       dma_start;
    logic       poly_hi_we;
    logic       poly_lo_we;
    logic       data_we;
    logic [7:0] wdata;
  } pcrc_cpu_wr_t;

  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] poly;
    logic [15:0] res;
    pcrc_mode_t  mode;
    logic        irq;
  } pcrc_state_t;
endpackage
`default_nettype wire

/* File: design/pcrc_top.sv */
// Programmable CRC engine with processor and DMA byte feed
// Functional notes
// - Clear with seed bit set loads the accumulator with all ones.
// - Writing the clear bit resets the accumulator before a new calculation.
// - Polynomial loads through high and low byte writes before data.
// - Every data byte written outside a DMA run is folded into the CRC with the polynomial, unless a clear flushes it first.
// - Invert complements the result, flip bit-reverses it, separately or together.
// - Shaped result is readable as a high byte and a low byte.
// - All block writes decode only on register page two.
// - DMA request offered only when channel request field equals two.
// - Setting the DMA mode bit starts a DMA-fed CRC run.
// - Channel config bit 7 lets end of transfer raise the interrupt.
`default_nettype none

module pcrc_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         flush_i,
  input  wire logic         in_valid_i,
  output logic             in_ready_o,
  input  wire logic [W-1:0] in_data_i,
  output logic             out_valid_o,
  input  wire logic         out_ready_i,
  output logic     [W-1:0] out_data_o
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [AW:0] wp;
    logic [AW:0] rp;
  } pcrc_fifo_st_t;

  pcrc_fifo_st_t st;
  pcrc_fifo_st_t next_st;
  logic [W-1:0]  mem [D];
  logic          push;
  logic          pop;

  assign in_ready_o  = !((st.wp[AW] != st.rp[AW]) && (st.wp[AW-1:0] == st.rp[AW-1:0]));
  assign out_valid_o = (st.wp != st.rp);
  assign out_data_o  = mem[st.rp[AW-1:0]];
  assign push        = in_valid_i && in_ready_o && !flush_i;
  assign pop         = out_valid_o && out_ready_i && !flush_i;

  always_comb begin
    next_st = st;
    if (flush_i) begin
      next_st.rp = st.wp;
    end else begin
      if (push) next_st.wp = (AW+1)'(st.wp + 1'b1);
      if (pop) next_st.rp = (AW+1)'(st.rp + 1'b1);
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage has no reset, so its contents never gate control
  always_ff @(posedge core_clk_i) begin
    if (push) mem[st.wp[AW-1:0]] <= in_data_i;
  end
endmodule

module pcrc_top #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic [7:0]            page_i,
  input  wire pcrc_pkg::pcrc_cpu_wr_t cpu_wr_i,
  input  wire logic                  invert_i,
  input  wire logic                  flip_i,
  input  wire logic [7:0]            chan_cfg_i,
  input  wire logic                  dma_valid_i,
  input  wire logic [7:0]            dma_data_i,
  input  wire logic                  dma_done_i,
  input  wire logic                  irq_clr_i,
  output logic                      dma_req_o,
  output logic                      cpu_ready_o,
  output logic                      dma_active_o,
  output logic                      dma_irq_o,
  output logic [7:0]                result_hi_o,
  output logic [7:0]                result_lo_o
);
  import pcrc_pkg::*;

  function automatic logic [15:0] crc_byte(input logic [15:0] acc, input logic [7:0] b,
                                           input logic [15:0] poly);
    logic [15:0] a;
    a = acc ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      a = a[15] ? ({a[14:0], 1'b0} ^ poly) : {a[14:0], 1'b0};
    end
    return a;
  endfunction

  function automatic logic [15:0] shape(input logic [15:0] acc, input logic invert_output_bit,
                                        input logic flp);
    logic [15:0] v;
    v = acc;
    if (flp) begin
      for (int i = 0; i < 16; i++) v[i] = acc[15-i];
    end
    return invert_output_bit ? ~v : v;
  endfunction

  pcrc_state_t st;
  pcrc_state_t next_st;
  logic        pg_ok;
  logic        req_ok;
  logic        stall;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [7:0]  f_in_data;
  logic        f_out_valid;
  logic [7:0]  f_out_data;
  logic        pop;

  assign pg_ok  = (page_i == PCRC_PAGE);
  assign req_ok = (chan_cfg_i[PCRC_CFG_REQ_LSB +: 4] == PCRC_DMA_SRC);
  // Clear and polynomial writes hold the drain so no byte straddles the change
  assign stall  = pg_ok && (cpu_wr_i.clr || cpu_wr_i.poly_hi_we || cpu_wr_i.poly_lo_we);
  assign pop    = f_out_valid && !stall;

  // Processor data writes are ignored while a DMA run owns the input
  assign f_in_valid  = (st.mode == PCRC_DMA) ? (dma_valid_i && req_ok)
                                             : (cpu_wr_i.data_we && pg_ok);
  assign f_in_data   = (st.mode == PCRC_DMA) ? dma_data_i : cpu_wr_i.wdata;
  assign dma_req_o   = (st.mode == PCRC_DMA) && req_ok && f_in_ready;
  assign cpu_ready_o = (st.mode == PCRC_IDLE) && f_in_ready;

  pcrc_fifo #(
    .W (PCRC_BYTE_W),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .flush_i     (pg_ok && cpu_wr_i.clr),
    .in_valid_i  (f_in_valid),
    .in_ready_o  (f_in_ready),
    .in_data_i   (f_in_data),
    .out_valid_o (f_out_valid),
    .out_ready_i (!stall),
    .out_data_o  (f_out_data)
  );

  always_comb begin
    next_st = st;
    if (pg_ok && cpu_wr_i.clr) begin
      next_st.acc = cpu_wr_i.seed ? PCRC_SEED_ONES : PCRC_SEED_ZERO;
    end else if (pop) begin
      next_st.acc = crc_byte(st.acc, f_out_data, st.poly);
    end
    if (pg_ok && cpu_wr_i.poly_hi_we) next_st.poly[15:8] = cpu_wr_i.wdata;
    if (pg_ok && cpu_wr_i.poly_lo_we) next_st.poly[7:0] = cpu_wr_i.wdata;
    case (st.mode)
      PCRC_IDLE: if (pg_ok && cpu_wr_i.dma_start) next_st.mode = PCRC_DMA;
      PCRC_DMA:  if (dma_done_i) next_st.mode = PCRC_IDLE;
      default:   next_st.mode = PCRC_IDLE;
    endcase
    // Set beats clear so a completion is never lost
    if (dma_done_i && chan_cfg_i[PCRC_CFG_IRQ_EN]) next_st.irq = 1'b1;
    else if (irq_clr_i) next_st.irq = 1'b0;
    next_st.res = shape(next_st.acc, invert_i, flip_i);
  end

  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st <= '{acc: PCRC_SEED_ZERO, poly: PCRC_POLY_RST, res: PCRC_RES_RST,
              mode: PCRC_IDLE, irq: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign result_hi_o  = st.res[15:8];
  assign result_lo_o  = st.res[7:0];
  assign dma_active_o = (st.mode == PCRC_DMA);
  assign dma_irq_o    = st.irq;

  sequence s_seed_clear;
    pg_ok && cpu_wr_i.clr && cpu_wr_i.seed;
  endsequence
  sequence s_zero_clear;
    pg_ok && cpu_wr_i.clr && !cpu_wr_i.seed;
  endsequence

  a_seed_ones: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_seed_clear |=> st.acc == 16'hffff) else $error("seeded clear not all ones");
  a_clear_zero: assert property (@(posedge core_clk_i) disable iff (rst_i)
    s_zero_clear |=> st.acc == 16'h0000 ##1 1'b1) else $error("clear not zero");
  a_clear_flush: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pg_ok && cpu_wr_i.clr && !f_in_valid |=> !f_out_valid) else $error("clear left bytes");
  a_poly_high: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pg_ok && cpu_wr_i.poly_hi_we |=> st.poly[15:8] == $past(cpu_wr_i.wdata))
    else $error("poly high byte not loaded");
  a_byte_fold: assert property (@(posedge core_clk_i) disable iff (rst_i)
    pop |=> st.acc == crc_byte($past(st.acc), $past(f_out_data), $past(st.poly)))
    else $error("byte not folded");
  a_result_shape: assert property (@(posedge core_clk_i) disable iff (rst_i)
    !$past(rst_i) |-> {result_hi_o, result_lo_o} == shape(st.acc, $past(invert_i),
    $past(flip_i))) else $error("result shape wrong");
  a_page_gate: assert property (@(posedge core_clk_i) disable iff (rst_i)
    page_i != PCRC_PAGE |=> $stable(st.poly)) else $error("write off page took effect");
  a_dma_request: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dma_req_o |-> st.mode == PCRC_DMA && chan_cfg_i[3:0] == 4'h2)
    else $error("request outside DMA run");
  a_dma_start: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.mode == PCRC_IDLE && pg_ok && cpu_wr_i.dma_start |=> dma_active_o)
    else $error("DMA run not started");
  a_irq_raise: assert property (@(posedge core_clk_i) disable iff (rst_i)
    dma_done_i && chan_cfg_i[7] |=> dma_irq_o) else $error("done did not raise irq");
  // A full FIFO would make the processor wait, which one fold per cycle must prevent
  a_no_wait: assert property (@(posedge core_clk_i) disable iff (rst_i)
    st.mode == PCRC_IDLE |-> cpu_ready_o)
    else $error("processor write would wait");
endmodule
`default_nettype wire

/* File: verification/pcrc_dma_model.sv */
// DMA channel model that feeds a byte block into the CRC block
`default_nettype none
module pcrc_dma_model #(
  parameter logic [7:0] N = 8'h03
) (
  input  wire logic       core_clk_i,
  input  wire logic       rst_i,
  input  wire logic       go_i,
  input  wire logic       slow_i,
  input  wire logic       req_i,
  output logic            valid_o,
  output logic [7:0]      data_o,
  output logic            done_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic       run;
  logic [7:0] sent;
  logic [7:0] nxt;
  // A byte counts only at an edge where the block requested it
  assign nxt = sent + {7'h00, valid_o & req_i};
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      run <= 1'b0;
      sent <= 8'h00;
      valid_o <= 1'b0;
      data_o <= 8'h5a;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      sent <= nxt;
      if (go_i) begin
        run <= 1'b1;
        sent <= 8'h00;
      end else if (run && nxt == N) begin
        run <= 1'b0;
        valid_o <= 1'b0;
        done_o <= 1'b1;
      end else if (run && (nxt != sent || !valid_o)) begin
        // Offered bytes are held until taken; idle lines toggle
        valid_o <= !slow_i;
        data_o <= slow_i ? ~data_o : 8'h31 + nxt;
      end else if (!run) begin
        data_o <= ~data_o;
      end
    end
  end
endmodule
`default_nettype wire

/* File: verification/pcrc_top_test.sv */
// Self-checking bench for the programmable CRC block
`default_nettype none
module pcrc_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import pcrc_pkg::*;
  typedef struct packed {
    logic [15:0] poly;
    logic        seed;
    logic        invert_output_bit;
    logic        flp;
    logic [7:0]  b0;
    logic [7:0]  b1;
  } pcrc_row_t;
  pcrc_row_t    rows [4] = '{'{16'h1021, 1'b1, 1'b0, 1'b0, 8'h31, 8'h32},
    '{16'h8005, 1'b0, 1'b1, 1'b0, 8'ha5, 8'hff}, '{16'h1021, 1'b0, 1'b0, 1'b1, 8'h00, 8'h80},
    '{16'h3d65, 1'b1, 1'b1, 1'b1, 8'h7e, 8'h01}};
  logic         core_clk_i = 1'b0, rst_i = 1'b1, invert_i = 1'b0, flip_i = 1'b0;
  logic         irq_clr_i = 1'b0, go = 1'b0, slow = 1'b0;
  logic [7:0]   page_i = 8'h02, chan_cfg_i = 8'h00;
  pcrc_cpu_wr_t cpu_wr_i = '0;
  logic         dvalid, ddone, dma_req_o, cpu_ready_o, dma_active_o, dma_irq_o;
  logic [7:0]   ddata, result_hi_o, result_lo_o;
  logic [15:0]  exp;
  int           fail_count = 0, n_checks = 0, k;
  always #20 core_clk_i = ~core_clk_i;
  pcrc_top #(.FIFO_DEPTH(PCRC_FIFO_DEPTH)) i_pcrc_top (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .page_i(page_i), .cpu_wr_i(cpu_wr_i), .invert_i(invert_i),
    .flip_i(flip_i), .chan_cfg_i(chan_cfg_i), .dma_valid_i(dvalid), .dma_data_i(ddata),
    .dma_done_i(ddone), .irq_clr_i(irq_clr_i), .dma_req_o(dma_req_o),
    .cpu_ready_o(cpu_ready_o), .dma_active_o(dma_active_o), .dma_irq_o(dma_irq_o),
    .result_hi_o(result_hi_o), .result_lo_o(result_lo_o));
  pcrc_dma_model i_pcrc_dma_model (.core_clk_i(core_clk_i), .rst_i(rst_i), .go_i(go),
    .slow_i(slow), .req_i(dma_req_o), .valid_o(dvalid), .data_o(ddata), .done_o(ddone));
  function automatic logic [15:0] upd(logic [15:0] a, logic [15:0] p, logic [7:0] b);
    a = a ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) a = a[15] ? ((a << 1) ^ p) : (a << 1);
    return a;
  endfunction
  function automatic logic [15:0] shp(logic [15:0] a, logic i, logic f);
    if (f) a = {<<{a}};
    return i ? ~a : a;
  endfunction
  task automatic chk(input logic [15:0] seen, input logic [15:0] ex, input string what);
    n_checks++;
    if (seen !== ex) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, ex, seen);
    end
  endtask
  task automatic wr(input logic [5:0] f, input logic [7:0] d);
    @(negedge core_clk_i);
    cpu_wr_i = {f, d};
  endtask
  task automatic idle(input int n);
    wr(6'h00, 8'h00);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge core_clk_i);
    rst_i = 1'b0;
    chk({result_hi_o, result_lo_o}, PCRC_RES_RST, "reset result");
    chk({14'h0000, cpu_ready_o, dma_req_o}, 16'h0002, "reset ready");
    foreach (rows[r]) begin
      wr({1'b1, rows[r].seed, 4'h0}, 8'h00);
      wr(6'h04, rows[r].poly[15:8]);
      wr(6'h02, rows[r].poly[7:0]);
      wr(6'h01, rows[r].b0);
      wr(6'h01, rows[r].b1);
      invert_i = rows[r].invert_output_bit;
      flip_i = rows[r].flp;
      idle(3);
      exp = upd(rows[r].seed ? PCRC_SEED_ONES : PCRC_SEED_ZERO, rows[r].poly, rows[r].b0);
      exp = shp(upd(exp, rows[r].poly, rows[r].b1), rows[r].invert_output_bit, rows[r].flp);
      chk({result_hi_o, result_lo_o}, exp, "crc result");
      page_i = 8'h03;
      wr(6'h2d, 8'h55);
      idle(2);
      page_i = 8'h02;
      chk({result_hi_o, result_lo_o}, exp, "off page result");
      invert_i = 1'b0;
      flip_i = 1'b0;
    end
    chan_cfg_i = 8'h83;
    wr(6'h20, 8'h00);
    wr(6'h04, 8'h80);
    wr(6'h02, 8'h05);
    wr(6'h08, 8'h00);
    idle(1);
    chk({14'h0000, dma_active_o, dma_req_o}, 16'h0002, "dma active");
    chk({15'h0000, cpu_ready_o}, 16'h0000, "cpu ready in dma");
    // Processor byte during a DMA run must be dropped, the final result proves it
    wr(6'h01, 8'hee);
    idle(0);
    chan_cfg_i = 8'h82;
    go = 1'b1;
    slow = 1'b1;
    @(negedge core_clk_i);
    go = 1'b0;
    repeat (4) @(negedge core_clk_i);
    slow = 1'b0;
    for (k = 0; k < 200 && dma_irq_o !== 1'b1; k++) @(negedge core_clk_i);
    if (k == 200) begin
      fail_count++;
    end else begin
      idle(2);
      exp = upd(upd(upd(PCRC_SEED_ZERO, 16'h8005, 8'h31), 16'h8005, 8'h32), 16'h8005, 8'h33);
      chk({result_hi_o, result_lo_o}, exp, "dma result");
      chk({14'h0000, dma_active_o, dma_irq_o}, 16'h0001, "dma irq");
      irq_clr_i = 1'b1;
      @(negedge core_clk_i);
      irq_clr_i = 1'b0;
      @(negedge core_clk_i);
      chk({15'h0000, dma_irq_o}, 16'h0000, "irq cleared");
      // Reset after the DMA run must drop the old result and the loaded polynomial
      rst_i = 1'b1;
      repeat (2) @(negedge core_clk_i);
      rst_i = 1'b0;
      chk({result_hi_o, result_lo_o}, PCRC_RES_RST, "mid reset result");
      chk({13'h0000, cpu_ready_o, dma_active_o, dma_irq_o}, 16'h0004, "mid reset state");
      wr(6'h30, 8'h00);
      wr(6'h01, 8'hab);
      idle(2);
      exp = upd(PCRC_SEED_ONES, PCRC_POLY_RST, 8'hab);
      chk({result_hi_o, result_lo_o}, exp, "reset poly fold");
    end
    tally_and_finish();
  end
endmodule
`default_nettype wire
